// *** logic/ems_strobe_ctrl.sv ***
/*
  external memory strobe controller: latch pulse, program read strobe,
  data read and write strobes and the multiplexed address/data bus.
  assumes core requests on the same clock and pins synchronised here.
*/
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ems_strobe_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // core side
  input  wire logic [15:0] fetchAddr,
  input  wire logic        dataReq,
  input  wire logic        dataWrite,
  input  wire logic [15:0] dataAddr,
  input  wire logic [7:0]  dataWdata,
  output logic      [7:0]  dataRdata,
  output logic             dataDone,
  output logic             dataBusy,
  // pins
  input  wire logic        external_code_select,
  input  wire logic        aleIn,
  output logic             aleOut,
  output logic             aleOe,
  output logic             program_read_strobe_n,
  output logic             wrStrobeN,
  output logic             rdStrobeN,
  input  wire logic [7:0]  adIn,
  output logic      [7:0]  adOut,
  output logic             adOe,
  output logic      [7:0]  addrHigh
);

  logic [2:0] tick;
  logic       slotOdd;
  logic       slotLast;
  logic       aleOff;
  logic [2:0] mode;
  logic       eaS1, eaS2, progS1, progS2;
  logic [7:0] adS1, adS2;
  logic       eaHold;
  logic [1:0] capCnt;
  logic       pending;
  logic       xferWrite;
  logic [15:0] xferAddr;
  logic [7:0] xferData;
  ems_pkg::ems_state_e state;
  logic       doubleSpeed, inProg, eaEff, codeExt, accept;
  logic [2:0] aleLast, psFirst;
  logic       next_ale, next_psenN, next_wrN, next_rdN, next_adOe;
  logic [7:0] next_adOut, next_addrHigh;

  ems_slot_timer u_timer (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ce          (ce),
    .doubleSpeed (doubleSpeed),
    .tick        (tick),
    .slotOdd     (slotOdd),
    .slotLast    (slotLast)
  );

  assign doubleSpeed = mode[ems_pkg::MODE_X2];
  assign inProg      = mode[ems_pkg::MODE_FLASH];
  assign aleLast = doubleSpeed ? ems_pkg::ALE_LAST_X2
                               : ems_pkg::ALE_LAST_STD;
  assign psFirst = doubleSpeed ? ems_pkg::PROGRAM_READ_STROBE_FIRST_X2
                               : ems_pkg::PROGRAM_READ_STROBE_FIRST_STD;
  // held select replaces the live pin under security level 1
  assign eaEff   = mode[ems_pkg::MODE_SEC1] ? eaHold : eaS2;
  // low select: all of 0000h-ffffh fetched outside
  assign codeExt = ~eaEff;
  // data accesses start at the end of the first slot of a cycle
  assign accept  = pending && (state == ems_pkg::ST_IDLE) &&
                   slotLast && !slotOdd;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eaS1   <= 1'b1;
      eaS2   <= 1'b1;
      progS1 <= 1'b0;
      progS2 <= 1'b0;
      adS1   <= 8'h00;
      adS2   <= 8'h00;
    end else if (ce) begin
      eaS1   <= external_code_select;
      eaS2   <= eaS1;
      progS1 <= aleIn;
      progS2 <= progS1;
      adS1   <= adIn;
      adS2   <= adS1;
    end
  end

  // select is caught once the synchroniser has filled after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      capCnt <= 2'h0;
      eaHold <= 1'b1;
    // one extra clock: the sync holds its reset value until then
    end else if (ce && capCnt <= ems_pkg::EA_CAP_WAIT) begin
      capCnt <= capCnt + 2'h1;
      eaHold <= eaS2;
    end
  end

  // register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aleOff <= ems_pkg::AUX_RST;
      mode   <= ems_pkg::MODE_RST;
    end else if (ce && regWr) begin
      if (regAddr == ems_pkg::REG_AUX)
        aleOff <= regWdata[ems_pkg::AUX_ALE_OFF];
      if (regAddr == ems_pkg::REG_MODE)
        mode <= regWdata[2:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (ce) begin
      regRdata <= 8'h00;
      if (regRd) begin
        case (regAddr)
          ems_pkg::REG_AUX:  regRdata <= {7'h00, aleOff};
          ems_pkg::REG_MODE: regRdata <= {5'h00, mode};
          ems_pkg::REG_STAT: regRdata <= {4'h0, dataBusy, progS2,
                                          eaHold, codeExt};
          default:           regRdata <= 8'h00;
        endcase
      end
    end
  end

  // request flag: a new request beats the clear of the old one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (ce) begin
      if (dataReq)
        pending <= 1'b1;
      else if (accept)
        pending <= 1'b0;
    end
  end

  // data access sequence: address slot, then transfer slot
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state     <= ems_pkg::ST_IDLE;
      xferWrite <= 1'b0;
      xferAddr  <= 16'h0000;
      xferData  <= 8'h00;
    end else if (ce) begin
      case (state)
        ems_pkg::ST_IDLE: begin
          if (accept) begin
            state     <= ems_pkg::ST_ADDR;
            xferWrite <= dataWrite;
            xferAddr  <= dataAddr;
            xferData  <= dataWdata;
          end
        end
        ems_pkg::ST_ADDR: begin
          if (slotLast)
            state <= ems_pkg::ST_XFER;
        end
        ems_pkg::ST_XFER: begin
          if (slotLast)
            state <= ems_pkg::ST_IDLE;
        end
        default: state <= ems_pkg::ST_IDLE;
      endcase
    end
  end

  // completion and read capture; adIn is two clocks late at slot end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dataDone  <= 1'b0;
      dataRdata <= 8'h00;
      dataBusy  <= 1'b0;
    end else if (ce) begin
      dataDone <= (state == ems_pkg::ST_XFER) && slotLast;
      dataBusy <= pending || (state != ems_pkg::ST_IDLE);
      if (state == ems_pkg::ST_XFER && slotLast && !xferWrite)
        dataRdata <= adS2;
    end
  end

  // strobe decode for the coming clock
  always_comb begin
    next_ale      = 1'b0;
    next_psenN    = 1'b1;
    next_wrN      = 1'b1;
    next_rdN      = 1'b1;
    next_adOe     = 1'b0;
    next_adOut    = 8'h00;
    next_addrHigh = fetchAddr[15:8];
    if (!inProg) begin
      case (state)
        ems_pkg::ST_IDLE: begin
          // latch runs free unless disabled on internal code
          next_ale   = (tick <= aleLast) && (codeExt || !aleOff);
          // two strobes per cycle, one per slot, none inside
          next_psenN = !(codeExt && tick >= psFirst);
          // low address valid while the latch is high
          next_adOe  = codeExt && (tick <= aleLast + 3'h1);
          next_adOut = fetchAddr[7:0];
        end
        ems_pkg::ST_ADDR: begin
          // latch kept even with aleOff: it carries the data address
          next_ale      = (tick <= aleLast);
          next_adOe     = (tick <= aleLast + 3'h1);
          next_adOut    = xferAddr[7:0];
          next_addrHigh = xferAddr[15:8];
        end
        ems_pkg::ST_XFER: begin
          // no latch, no program read in this slot
          next_addrHigh = xferAddr[15:8];
          next_wrN   = !(xferWrite && tick != 3'h0);
          next_rdN   = !(!xferWrite && tick != 3'h0);
          next_adOe  = xferWrite;
          next_adOut = xferData;
        end
        default: begin
          next_ale = 1'b0;
        end
      endcase
    end
  end

  // pin registers; latch pin released while programming
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aleOut                <= 1'b0;
      aleOe                 <= 1'b1;
      program_read_strobe_n <= 1'b1;
      wrStrobeN             <= 1'b1;
      rdStrobeN             <= 1'b1;
      adOe                  <= 1'b0;
      adOut                 <= 8'h00;
      addrHigh              <= 8'h00;
    end else if (ce) begin
      aleOut                <= next_ale;
      aleOe                 <= !inProg;
      program_read_strobe_n <= next_psenN;
      wrStrobeN             <= next_wrN;
      rdStrobeN             <= next_rdN;
      adOe                  <= next_adOe;
      adOut                 <= next_adOut;
      addrHigh              <= next_addrHigh;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // helper: clocks between latch rises, spoiled by mode or gating
  logic [4:0] aleGap;
  logic       gapClean;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aleGap   <= 5'h00;
      gapClean <= 1'b0;
    end else if (aleOut && !$past(aleOut)) begin
      aleGap   <= 5'h01;
      gapClean <= ce;
    end else begin
      aleGap <= aleGap + 5'h01;
      if (!ce || aleOff || inProg || $changed(doubleSpeed))
        gapClean <= 1'b0;
    end
  end

  AST_ALE_PERIOD: assert property (
    ($rose(aleOut) && gapClean && ce) |->
      (aleGap == {2'h0, u_timer.slotLen} ||
       aleGap == {1'b0, u_timer.slotLen, 1'b0}))
    else $error("latch pulse spacing wrong");

  AST_ALE_SKIP: assert property (
    (ce && state == ems_pkg::ST_XFER) |=> !aleOut)
    else $error("latch pulse not skipped in transfer");

  AST_ALE_OFF_INT: assert property (
    (ce && aleOff && !codeExt && state == ems_pkg::ST_IDLE) |=> !aleOut)
    else $error("latch active on internal fetch");

  AST_PROGRAM_READ_STROBE_SKIP: assert property (
    (ce && state != ems_pkg::ST_IDLE) |=> program_read_strobe_n)
    else $error("program read during data access");

  AST_PROGRAM_READ_STROBE_INT: assert property (
    (ce && !codeExt) |=> program_read_strobe_n)
    else $error("program read on internal fetch");

  AST_PROGRAM_READ_STROBE_SLOT: assert property (
    (ce && codeExt && !inProg && state == ems_pkg::ST_IDLE && !pending
     && tick == 3'h0 && !dataReq) ##1 (ce && codeExt && !inProg) [*3]
    |-> ##[0:1] !program_read_strobe_n)
    else $error("program read missing in slot");

  AST_ALE_ADDR: assert property (
    (ce && !inProg && state == ems_pkg::ST_ADDR && tick == 3'h0) |=>
      (aleOut && adOe && adOut == xferAddr[7:0]))
    else $error("latch pulse missing on data address");

  AST_WR_CAUSE: assert property (
    $fell(wrStrobeN) |-> $past(state) == ems_pkg::ST_XFER && xferWrite)
    else $error("write strobe outside write transfer");

  AST_RD_CAUSE: assert property (
    $fell(rdStrobeN) |-> $past(state) == ems_pkg::ST_XFER && !xferWrite)
    else $error("read strobe outside read transfer");

  AST_PROGRAM_PULSE_INPUT_PIN: assert property (
    (ce && inProg) |=> !aleOe && !aleOut)
    else $error("latch pin driven while programming");

  AST_EA_HELD: assert property (
    (capCnt > ems_pkg::EA_CAP_WAIT) |=> $stable(eaHold))
    else $error("held code select changed");

  CVR_READ: cover property (!rdStrobeN ##[1:12] dataDone);
  CVR_WRITE: cover property (!wrStrobeN ##[1:12] dataDone);
  CVR_X2_ALE: cover property (doubleSpeed && $rose(aleOut));
  CVR_EXT_CODE: cover property (codeExt && $fell(program_read_strobe_n));

endmodule
`default_nettype wire

// *** logic/ems_pkg.sv ***
/*
  constants, register map and state codes of the external memory
  strobe control block.
  assumes one 20 MHz oscillator clock and a plain register port.
*/
// What this block does
// - the latch pulse runs at one sixth of the clock, one third in x2.
// - during external access the latch pulse marks a valid low address.
// - each external data access drops exactly one latch pulse.
// - bit 0 of the auxiliary control register disables the latch pulse.
// - with that bit set the latch stays low during internal fetches.
// - external code execution strobes program read twice per cycle.
// - each external data access drops two program read strobes.
// - program read never strobes for internal program fetches.
// - code select held low sends every fetch 0000h-ffffh outside.
// - with security level 1 the code select is caught at reset and held.
// - in flash programming the latch pin is an input for the pulse.
// - a write strobe is driven for every external data write outside flash programming.
// - a read strobe is driven for every external data read outside flash programming.
package ems_pkg;

  // register offsets
  localparam logic [7:0] REG_AUX  = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;

  // field positions
  localparam int AUX_ALE_OFF   = 0;
  localparam int MODE_X2       = 0;
  localparam int MODE_SEC1     = 1;
  localparam int MODE_FLASH    = 2;
  localparam int STAT_EXT      = 0;
  localparam int STAT_EA_HOLD  = 1;
  localparam int STAT_PROGRAM_PULSE_INPUT_IN  = 2;
  localparam int STAT_BUSY     = 3;

  // reset values
  localparam logic       AUX_RST  = 1'h0;
  localparam logic [2:0] MODE_RST = 3'h0;

  // slot timing in clocks, two slots per machine cycle
  localparam logic [2:0] SLOT_STD       = 3'h6;
  localparam logic [2:0] SLOT_X2        = 3'h3;
  localparam logic [2:0] ALE_LAST_STD   = 3'h1;
  localparam logic [2:0] ALE_LAST_X2    = 3'h0;
  localparam logic [2:0] PROGRAM_READ_STROBE_FIRST_STD = 3'h3;
  localparam logic [2:0] PROGRAM_READ_STROBE_FIRST_X2  = 3'h2;
  localparam logic [1:0] EA_CAP_WAIT    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_XFER = 3'b100
  } ems_state_e;

endpackage

// *** logic/ems_slot_timer.sv ***
/*
  slot timer: clock index inside a bus slot and which half of the
  machine cycle is running.
  assumes the same clock, reset and enable as the strobe controller.
*/
`timescale 1ns/10ps
`default_nettype none
module ems_slot_timer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // mode
  input  wire logic       doubleSpeed,
  // slot position
  output logic      [2:0] tick,
  output logic            slotOdd,
  output logic            slotLast
);

  logic [2:0] slotLen;

  // slot length sets the latch rate
  assign slotLen = doubleSpeed ? ems_pkg::SLOT_X2 : ems_pkg::SLOT_STD;
  // >= so a mode switch mid-slot cannot run past the end
  assign slotLast = (tick >= slotLen - 3'h1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick    <= 3'h0;
      slotOdd <= 1'b0;
    end else if (ce) begin
      if (slotLast) begin
        tick    <= 3'h0;
        slotOdd <= ~slotOdd;
      end else begin
        tick <= tick + 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/ems_ext_mem_model.sv ***
/*
  external address latch plus a small data memory on the muxed bus.
  assumes the strobe controller's registered pins on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ems_ext_mem_model (
  // clock
  input  wire logic       ref_clk,
  // pins from the controller
  input  wire logic       aleOut,
  input  wire logic       aleOe,
  input  wire logic       wrStrobeN,
  input  wire logic       rdStrobeN,
  input  wire logic [7:0] adOut,
  input  wire logic       adOe,
  // bus back to the controller
  output logic      [7:0] adBus
);
  logic [7:0] mem [256];
  logic [7:0] lowAddr;
  logic [7:0] lastVal;

  initial begin
    lowAddr = 8'h00;
    lastVal = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end

  // latch is transparent while the pulse is high
  always @(posedge ref_clk) begin
    if (aleOut && aleOe && adOe) begin
      lowAddr <= adOut;
    end
    if (!wrStrobeN && adOe) begin
      mem[lowAddr] <= adOut;
    end
    if (!rdStrobeN) begin
      lastVal <= mem[lowAddr];
    end
  end

  // released bus shows the inverse of the last value, never a kind one
  assign adBus = !rdStrobeN ? mem[lowAddr] : ~lastVal;
endmodule
`default_nettype wire

// *** bench/ems_strobe_ctrl_tb.sv ***
/*
  bench for the strobe controller: registers, latch and program read
  cadence, external data accesses, flash programming and held select.
  assumes ems_ext_mem_model as the far side of the muxed bus.
*/
`timescale 1ns/10ps
`default_nettype none
module ems_strobe_ctrl_tb;
  logic        ref_clk, rst, regWr, regRd, dataReq, dataWrite;
  logic        dataDone, dataBusy, selPin, aleIn, aleOut, aleOe;
  logic        psenN, wrStrobeN, rdStrobeN, adOe, aleQ, psQ, ce;
  logic [7:0]  regAddr, regWdata, regRdata, dataWdata, dataRdata;
  logic [7:0]  adIn, adOut, addrHigh, rd, hiSeen;
  logic [15:0] fetchAddr, dataAddr;
  int          num_errors, tests_run, aleCnt, psCnt, wrCnt, rdCnt, doneCnt;

  ems_strobe_ctrl dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .fetchAddr(fetchAddr),
    .dataReq(dataReq), .dataWrite(dataWrite), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .dataRdata(dataRdata), .dataDone(dataDone),
    .dataBusy(dataBusy), .external_code_select(selPin), .aleIn(aleIn),
    .aleOut(aleOut), .aleOe(aleOe), .program_read_strobe_n(psenN),
    .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN), .adIn(adIn),
    .adOut(adOut), .adOe(adOe), .addrHigh(addrHigh));

  ems_ext_mem_model mem (.ref_clk(ref_clk), .aleOut(aleOut),
    .aleOe(aleOe), .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN),
    .adOut(adOut), .adOe(adOe), .adBus(adIn));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // edge counters for latch and program read; write, read and done counted per clock
  always @(posedge ref_clk) begin
    aleQ <= aleOut;
    psQ <= psenN;
    if (aleOut === 1'b1 && aleQ === 1'b0) aleCnt++;
    if (psenN === 1'b0 && psQ === 1'b1) psCnt++;
    if (wrStrobeN === 1'b0) wrCnt++;
    if (rdStrobeN === 1'b0) rdCnt++;
    if (wrStrobeN === 1'b0 || rdStrobeN === 1'b0) hiSeen <= addrHigh;
    if (dataDone === 1'b1) doneCnt++;
  end

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // count pulses over a whole number of periods
  task automatic count_window(input int n, input int expAle,
                              input int expPs);
    // settle first, then count off the edge so no pulse is split
    clocks(2);
    #1;
    aleCnt = 0;
    psCnt = 0;
    clocks(n);
    #1;
    check("ale pulses", 16'(expAle), 16'(aleCnt));
    check("program_read_strobe pulses", 16'(expPs), 16'(psCnt));
  endtask

  task automatic t_reset_regs();
    reg_rd(ems_pkg::REG_AUX, rd);
    check("aux reset", 16'h0000, {8'h00, rd});
    @(posedge ref_clk);
    #1;
    check("read data cleared", 16'h0000, {8'h00, regRdata});
    reg_rd(ems_pkg::REG_MODE, rd);
    check("mode reset", 16'h0000, {8'h00, rd});
    reg_rd(8'h07, rd);
    check("unmapped read", 16'h0000, {8'h00, rd});
    reg_rd(ems_pkg::REG_STAT, rd);
    check("status reset", 16'h0002, {8'h00, rd});
    check("ale drive", 16'h0001, {15'h0, aleOe});
  endtask

  task automatic t_internal();
    count_window(120, 20, 0);
    reg_wr(ems_pkg::REG_AUX, 8'h01);
    count_window(60, 0, 0);
    reg_wr(ems_pkg::REG_AUX, 8'h00);
  endtask

  task automatic t_external();
    selPin <= 1'b0;
    fetchAddr <= 16'hffff;
    clocks(6);
    reg_rd(ems_pkg::REG_STAT, rd);
    check("code external", 16'h0003, {8'h00, rd});
    count_window(120, 20, 20);
    reg_wr(ems_pkg::REG_MODE, 8'h01);
    clocks(6);
    count_window(120, 40, 40);
    reg_wr(ems_pkg::REG_MODE, 8'h00);
    clocks(12);
  endtask

  // one access inside a 48 clock window of eight periods
  task automatic access(input logic wr, input logic [7:0] d);
    @(posedge ref_clk);
    dataReq <= 1'b1;
    dataWrite <= wr;
    dataAddr <= 16'h0312;
    dataWdata <= d;
    #1;
    aleCnt = 0;
    psCnt = 0;
    wrCnt = 0;
    rdCnt = 0;
    doneCnt = 0;
    @(posedge ref_clk);
    dataReq <= 1'b0;
    clocks(47);
    #1;
    check("ale skip", 16'h0007, 16'(aleCnt));
    check("program_read_strobe skip", 16'h0006, 16'(psCnt));
    check("write strobe", {15'h0, wr}, {15'h0, wrCnt > 0});
    check("read strobe", {15'h0, !wr}, {15'h0, rdCnt > 0});
    check("high address", 16'h0003, {8'h00, hiSeen});
    check("done pulse", 16'h0001, 16'(doneCnt));
    check("busy idle", 16'h0000, {15'h0, dataBusy});
  endtask

  // low enable freezes the pulse train
  task automatic t_freeze();
    @(posedge ref_clk);
    ce <= 1'b0;
    count_window(30, 0, 0);
    @(posedge ref_clk);
    ce <= 1'b1;
  endtask

  // second reset in mid-run with the select pin low
  task automatic t_held();
    @(posedge ref_clk);
    rst <= 1'b1;
    clocks(10);
    rst <= 1'b0;
    clocks(4);
    reg_rd(ems_pkg::REG_STAT, rd);
    check("held low", 16'h0001, {8'h00, rd});
    @(posedge ref_clk);
    selPin <= 1'b1;
    reg_wr(ems_pkg::REG_MODE, 8'h02);
    clocks(4);
    reg_rd(ems_pkg::REG_STAT, rd);
    check("held in use", 16'h0001, {8'h00, rd});
    reg_wr(ems_pkg::REG_MODE, 8'h00);
    clocks(4);
    reg_rd(ems_pkg::REG_STAT, rd);
    check("live select", 16'h0000, {8'h00, rd});
  endtask

  task automatic t_data();
    access(1'b1, 8'ha5);
    check("stored byte", 16'h00a5, {8'h00, mem.mem[8'h12]});
    access(1'b0, 8'h00);
    check("read byte", 16'h00a5, {8'h00, dataRdata});
  endtask

  task automatic t_flash();
    reg_wr(ems_pkg::REG_MODE, 8'h04);
    clocks(3);
    check("ale released", 16'h0000, {15'h0, aleOe});
    aleIn <= 1'b1;
    clocks(4);
    reg_rd(ems_pkg::REG_STAT, rd);
    check("program_pulse_input pulse in", 16'h0001, {15'h0, rd[2]});
    aleIn <= 1'b0;
    reg_wr(ems_pkg::REG_MODE, 8'h00);
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    num_errors++;
    print_verdict();
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    {regWr, regRd, dataReq, dataWrite, aleIn} = 5'h00;
    regAddr = 8'h00;
    regWdata = 8'h00;
    dataWdata = 8'h00;
    dataAddr = 16'h0000;
    fetchAddr = 16'h0100;
    selPin = 1'b1;
    ce = 1'b1;
    clocks(10);
    rst <= 1'b0;
    clocks(4);
    t_reset_regs();
    t_internal();
    t_external();
    t_freeze();
    t_data();
    t_flash();
    t_held();
    print_verdict();
  end
endmodule
`default_nettype wire
